// ### rtl/dtbu_pkg.sv
/*
  Constants, modes and carrier types of the dual timebase capture/compare unit.
  Assumes a 32-bit AXI4-Lite master and synchronous pins.
*/
`default_nettype none
package dtbu_pkg;
  localparam int unsigned NCH      = 16;
  localparam int unsigned AW       = 8;
  localparam int unsigned STAG_SHF = 3;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] T0_OFS    = 8'h04;
  localparam logic [7:0] RL0_OFS   = 8'h08;
  localparam logic [7:0] T1_OFS    = 8'h0c;
  localparam logic [7:0] RL1_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS  = 8'h14;
  localparam logic [7:0] MASK_OFS  = 8'h18;
  localparam logic [7:0] PIN_OFS   = 8'h1c;
  localparam logic [7:0] DBL_OFS   = 8'h20;
  localparam logic [1:0] VAL_AREA  = 2'h1;
  localparam logic [1:0] CFG_AREA  = 2'h2;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam logic [2:0] SEL_GPT   = 3'h6;
  localparam logic [2:0] SEL_EXT   = 3'h7;
  localparam logic [15:0] TMR_MAX  = 16'hffff;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000, CAP_RISE = 3'b001, CAP_FALL = 3'b010, CAP_BOTH = 3'b011,
    CMP_INT  = 3'b100, CMP_TOG  = 3'b101, CMP_ONCE = 3'b110, CMP_SET  = 3'b111
  } dtbu_mode_t;
  typedef struct packed {
    logic       single;
    logic       tsel;
    dtbu_mode_t mode;
  } dtbu_cfg_t;
  typedef struct packed {
    logic [2:0] clksel;
    logic       run;
  } dtbu_tctl_t;
  localparam dtbu_cfg_t  CFG_RST  = '{single: 1'b0, tsel: 1'b0, mode: MODE_OFF};
  localparam dtbu_tctl_t TCTL_RST = '{clksel: 3'h0, run: 1'b0};
endpackage
`default_nettype wire

// ### rtl/dtbu_top.sv
/*
  Dual timebase capture/compare unit: two reloadable timers, sixteen
  channels, AXI4-Lite registers, one level interrupt.
  Assumes pins, overflow pulse and count inputs synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dtbu_top
  import dtbu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [dtbu_pkg::AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [dtbu_pkg::AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  input  wire logic              gpt_ovf,
  input  wire logic [1:0]        ext_count,
  input  wire logic [15:0]       cc_pin_i,
  output logic [15:0]            cc_pin_o,
  output logic [15:0]            cc_pin_oe,
  output logic                   irq
);
  import dtbu_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  dtbu_tctl_t       tctl_q [2];
  logic             stag_q;
  logic [15:0]      tmr_q [2];
  logic [15:0]      rld_q [2];
  logic [1:0]       upd_q, ovf_q, tick;
  logic [4:0]       pre_q;
  logic [1:0]       ext_prev_q;
  logic [15:0]      val_q [NCH];
  dtbu_cfg_t        cfg_q [NCH];
  logic [NCH-1:0]   stat_q, mask_q, evt, match, pin_prev_q, done_q, fired_q;
  logic [7:0]       dbl_q;
  logic [AW-1:0]    awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             aw_hold_q, w_hold_q, wr_fire;
  logic [15:0]      bmask;
  logic [15:0]      wd;
  logic [31:0]      rd_d;
  logic             rd_ok;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign wr_fire = aw_hold_q & w_hold_q & ~s_bvalid;
  assign bmask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wd      = wdata_q[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = (old & ~bmask) | (wd & bmask);
  endfunction

  function automatic logic wr_hit(input logic [AW-1:0] ofs);
    wr_hit = wr_fire && awaddr_q == ofs;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OK;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q  <= s_awaddr;
        aw_hold_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
        w_hold_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (awaddr_q <= DBL_OFS || awaddr_q[7:6] == VAL_AREA || awaddr_q[7:6] == CFG_AREA)
                     ? RESP_OK : RESP_ERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always_comb begin
    rd_d  = '0;
    rd_ok = 1'b1;
    case (s_araddr[7:6])
      VAL_AREA: rd_d[15:0] = val_q[s_araddr[5:2]];
      CFG_AREA: rd_d[4:0]  = cfg_q[s_araddr[5:2]];
      default: begin
        case (s_araddr)
          CTRL_OFS: rd_d[8:0] = {stag_q, tctl_q[1], tctl_q[0]};
          T0_OFS:   rd_d[15:0] = tmr_q[0];
          RL0_OFS:  rd_d[15:0] = rld_q[0];
          T1_OFS:   rd_d[15:0] = tmr_q[1];
          RL1_OFS:  rd_d[15:0] = rld_q[1];
          STAT_OFS: rd_d[15:0] = stat_q;
          MASK_OFS: rd_d[15:0] = mask_q;
          PIN_OFS:  rd_d[15:0] = cc_pin_o;
          DBL_OFS:  rd_d[7:0]  = dbl_q;
          default:  rd_ok      = 1'b0;
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= RESP_OK;
    end else begin
      if (s_arvalid && s_arready) begin
        s_rdata   <= rd_d;
        s_rresp   <= rd_ok ? RESP_OK : RESP_ERR;
        s_rvalid  <= 1'b1;
        s_arready <= 1'b0;
      end else if (s_rvalid && s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tctl_q[0] <= TCTL_RST;
      tctl_q[1] <= TCTL_RST;
      stag_q    <= 1'b0;
      mask_q    <= '0;
      dbl_q     <= '0;
      rld_q[0]  <= '0;
      rld_q[1]  <= '0;
    end else begin
      if (wr_hit(CTRL_OFS) && wstrb_q[0])
        {tctl_q[1], tctl_q[0]} <= wd[7:0];
      if (wr_hit(CTRL_OFS) && wstrb_q[1])
        stag_q <= wd[8];
      if (wr_hit(MASK_OFS))
        mask_q <= merge(mask_q);
      if (wr_hit(DBL_OFS) && wstrb_q[0])
        dbl_q <= wd[7:0];
      if (wr_hit(RL0_OFS))
        rld_q[0] <= merge(rld_q[0]);
      if (wr_hit(RL1_OFS))
        rld_q[1] <= merge(rld_q[1]);
    end
  end

  // ----------------------------------------
  // Prescaler and count sources
  // ----------------------------------------
  // Staggered mode floors the division at eight, which costs resolution
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_q      <= '0;
      ext_prev_q <= '0;
    end else begin
      pre_q      <= pre_q + 5'h01;
      ext_prev_q <= ext_count;
    end
  end

  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      logic [2:0]  shf;
      logic [4:0]  pmask;
      always_comb begin
        shf = tctl_q[t].clksel;
        if (stag_q && shf < 3'(STAG_SHF))
          shf = 3'(STAG_SHF);
        pmask = 5'((6'h01 << shf) - 6'h01);
        case (tctl_q[t].clksel)
          SEL_GPT: tick[t] = tctl_q[t].run & gpt_ovf;
          SEL_EXT: tick[t] = tctl_q[t].run & ext_count[t] & ~ext_prev_q[t];
          default: tick[t] = tctl_q[t].run & ((pre_q & pmask) == pmask);
        endcase
      end
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          tmr_q[t] <= '0;
          upd_q[t] <= 1'b0;
          ovf_q[t] <= 1'b0;
        end else begin
          upd_q[t] <= tick[t];
          ovf_q[t] <= tick[t] && tmr_q[t] == TMR_MAX;
          if (wr_hit(t ? T1_OFS : T0_OFS))
            tmr_q[t] <= merge(tmr_q[t]);
          else if (tick[t])
            tmr_q[t] <= (tmr_q[t] == TMR_MAX) ? rld_q[t] : tmr_q[t] + 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [15:0] tval;
      logic        upd, ovf, is_cap, is_cmp, once, cap_hit, ptog, shadow;
      assign tval   = tmr_q[cfg_q[i].tsel];
      assign upd    = upd_q[cfg_q[i].tsel];
      assign ovf    = ovf_q[cfg_q[i].tsel];
      assign is_cap = ~cfg_q[i].mode[2] & (cfg_q[i].mode != MODE_OFF);
      assign is_cmp = cfg_q[i].mode[2];
      assign once   = cfg_q[i].mode == CMP_ONCE || cfg_q[i].mode == CMP_SET;
      assign cap_hit = is_cap & ~fired_q[i] &
                       ((cc_pin_i[i] & ~pin_prev_q[i] & cfg_q[i].mode[0]) |
                        (~cc_pin_i[i] & pin_prev_q[i] & cfg_q[i].mode[1]));
      // Overflow cycle rearms at once, so a compare on the reload value is kept
      assign match[i] = is_cmp & upd & tval == val_q[i] & ~fired_q[i] &
                        ~(once & done_q[i] & ~ovf);
      assign evt[i] = cap_hit | match[i];
      if (i < 8) begin : g_pair
        assign ptog   = dbl_q[i] & match[i+8];
        assign shadow = 1'b0;
      end else begin : g_sec
        assign ptog   = 1'b0;
        assign shadow = dbl_q[i-8];
      end
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          val_q[i]      <= '0;
          cfg_q[i]      <= CFG_RST;
          pin_prev_q[i] <= 1'b0;
          done_q[i]     <= 1'b0;
          fired_q[i]    <= 1'b0;
          cc_pin_o[i]   <= 1'b0;
          cc_pin_oe[i]  <= 1'b0;
        end else begin
          pin_prev_q[i] <= cc_pin_i[i];
          if (cap_hit)
            val_q[i] <= tval;
          else if (wr_fire && awaddr_q[7:6] == VAL_AREA && awaddr_q[5:2] == 4'(i))
            val_q[i] <= merge(val_q[i]);
          if (wr_fire && awaddr_q[7:6] == CFG_AREA && awaddr_q[5:2] == 4'(i) && wstrb_q[0]) begin
            cfg_q[i]   <= dtbu_cfg_t'(wd[4:0]);
            fired_q[i] <= 1'b0;
          end else if (evt[i] && cfg_q[i].single)
            fired_q[i] <= 1'b1;
          if (match[i])
            done_q[i] <= 1'b1;
          else if (ovf)
            done_q[i] <= 1'b0;
          // Pin drives only in pin modes, or when the partner shares it
          cc_pin_oe[i] <= ~shadow & ((cfg_q[i].mode == CMP_TOG) ||
                          (cfg_q[i].mode == CMP_SET) || ptog || (i < 8 && dbl_q[i % 8]));
          if ((match[i] && cfg_q[i].mode == CMP_TOG && !shadow) || ptog)
            cc_pin_o[i] <= ~cc_pin_o[i];
          else if (match[i] && cfg_q[i].mode == CMP_SET)
            cc_pin_o[i] <= 1'b1;
          else if (ovf && cfg_q[i].mode == CMP_SET)
            cc_pin_o[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status: set wins over write-one-clear
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stat_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (wr_hit(STAT_OFS) ? stat_q & ~(wd & bmask) : stat_q) | evt;
      irq    <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Helper: once-mode compare seen, until its timer wraps
  logic once6_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      once6_q <= 1'b0;
    else if (match[6] && cfg_q[6].mode == CMP_ONCE)
      once6_q <= 1'b1;
    else if (ovf_q[cfg_q[6].tsel])
      once6_q <= 1'b0;
  end

  sequence s_cap0;
    cfg_q[0].mode == CAP_RISE && !fired_q[0] && cc_pin_i[0] && !pin_prev_q[0];
  endsequence

  a_capture_latch: assert property (s_cap0 |=> val_q[0] == $past(tmr_q[cfg_q[0].tsel]) && stat_q[0])
    else $error("capture did not latch timer");
  a_cap_edge_fall: assert property (cfg_q[1].mode == CAP_FALL && !fired_q[1] && cc_pin_i[1]
                                    && !pin_prev_q[1] |=> !stat_q[1] || $past(stat_q[1]))
    else $error("rising edge captured in falling mode");
  a_timer_reload: assert property (tick[0] && tmr_q[0] == TMR_MAX && !wr_hit(T0_OFS)
                                   |=> tmr_q[0] == $past(rld_q[0]) && ovf_q[0])
    else $error("timer did not reload");
  a_timer_count: assert property (tick[1] && tmr_q[1] != TMR_MAX && !wr_hit(T1_OFS)
                                  |=> tmr_q[1] == $past(tmr_q[1]) + 16'h0001)
    else $error("timer did not advance");
  a_stag_tick: assert property (stag_q && tctl_q[1].clksel < SEL_GPT && tick[1] |=> !tick[1] [*7])
    else $error("staggered tick faster than eight cycles");
  a_toggle_pin: assert property (match[3] && cfg_q[3].mode == CMP_TOG |=> cc_pin_o[3] != $past(cc_pin_o[3]))
    else $error("pin did not toggle");
  a_set_pin: assert property (match[4] && cfg_q[4].mode == CMP_SET |=> cc_pin_o[4])
    else $error("pin not set on match");
  a_once_period: assert property (once6_q && !ovf_q[cfg_q[6].tsel] |-> !match[6])
    else $error("second match in one period");
  a_single_event: assert property (evt[7] && cfg_q[7].single && !wr_fire |=> fired_q[7] && !evt[7])
    else $error("single event repeated");
  a_irq_level: assert property (|(stat_q & mask_q) |=> irq)
    else $error("interrupt not raised");
  a_double_pin: assert property (dbl_q[1] && match[9] && !match[1] |=> cc_pin_o[1] != $past(cc_pin_o[1]))
    else $error("partner match did not toggle shared pin");

endmodule // dtbu_top
`default_nettype wire

// ### bench/dtbu_far_end.sv
/*
  Far-side model: channel pads, outside overflow pulse and count inputs.
  Assumes the bench calls its tasks from code running on sys_clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dtbu_far_end (
  input  wire logic        sys_clk,
  input  wire logic [15:0] cc_pin_o,
  input  wire logic [15:0] cc_pin_oe,
  output logic      [15:0] cc_pin_i,
  output logic             gpt_ovf,
  output logic      [1:0]  ext_count
);
  logic [15:0] drv;
  // ----------------------------------------
  // Pad level
  // ----------------------------------------
  // Pad follows the unit while driven, else the outside source
  assign cc_pin_i = (cc_pin_oe & cc_pin_o) | (~cc_pin_oe & drv);
  initial begin
    drv = 16'h0;
    gpt_ovf = 1'b0;
    ext_count = 2'h0;
  end
  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  task automatic set_pins(input logic [15:0] v);
    @(posedge sys_clk);
    drv <= v;
  endtask
  // Two cycles high so no synchroniser can miss the edge
  task automatic count_pulse(input int t);
    @(posedge sys_clk);
    ext_count[t] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ext_count[t] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic ovf_pulse;
    @(posedge sys_clk);
    gpt_ovf <= 1'b1;
    @(posedge sys_clk);
    gpt_ovf <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // dtbu_far_end
`default_nettype wire

// ### bench/tb_dual_timebase_capture_compare.sv
/*
  Self-checking bench: AXI4-Lite master, expectation queue and monitor.
  Assumes dtbu_pkg and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timebase_capture_compare;
  import dtbu_pkg::*;
  logic          sys_clk, reset_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, gpt_ovf;
  logic [AW-1:0] s_awaddr, s_araddr;
  logic [31:0]   s_wdata, s_rdata;
  logic [3:0]    s_wstrb;
  logic [1:0]    s_bresp, s_rresp, ext_count;
  logic [15:0]   cc_pin_i, cc_pin_o, cc_pin_oe, n;
  logic [33:0]   exp_q[$];
  logic [33:0]   e;
  int            fails, cmp_count, seed;
  dtbu_mode_t    md [5] = '{CMP_TOG, CMP_SET, CMP_INT, CMP_ONCE, CMP_TOG};

  dtbu_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .gpt_ovf(gpt_ovf),
    .ext_count(ext_count), .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o), .cc_pin_oe(cc_pin_oe),
    .irq(irq));
  dtbu_far_end far (.sys_clk(sys_clk), .cc_pin_o(cc_pin_o), .cc_pin_oe(cc_pin_oe),
    .cc_pin_i(cc_pin_i), .gpt_ovf(gpt_ovf), .ext_count(ext_count));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] tv(input logic [15:0] k);
    return {16'h0, 16'(n + k)};
  endfunction
  function automatic logic [31:0] cf(input logic s, input dtbu_mode_t m);
    return {27'h0, s, 1'b0, m};
  endfunction
  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask
  // Holds each channel until its own ready, bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK,
                    input logic [3:0] s = 4'hf);
    exp_q.push_back({r, 32'h0});
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= s;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    // One idle edge so the next call never re-raises bready in this step
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK);
    exp_q.push_back({r, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if ((s_bvalid && s_bready) || (s_rvalid && s_rready)) begin
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      check(s_bvalid ? {s_bresp, 32'h0} : {s_rresp, s_rdata}, e);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    s_awaddr = '0;
    s_araddr = '0;
    s_wdata = 32'h0;
    s_wstrb = 4'hf;
    fails = 0;
    cmp_count = 0;
    seed = $urandom(32'h0faa);
    n = 16'(1 + $urandom % 6);
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(CTRL_OFS, 32'h0);
    rd(STAT_OFS, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h24, 32'h0, RESP_ERR);
    wr(8'h24, 32'h1234, RESP_ERR);
    // Timer 0 on count input, timer 1 on outside overflow
    wr(CTRL_OFS, 32'h00df);
    repeat (n) far.count_pulse(0);
    repeat (3) far.ovf_pulse();
    settle();
    rd(T0_OFS, tv(0));
    rd(T1_OFS, 32'h3);
    wr(8'h80, cf(0, CAP_RISE));
    wr(8'h84, cf(0, CAP_FALL));
    wr(8'h88, cf(0, CAP_BOTH));
    far.set_pins(16'h0007);
    settle();
    far.count_pulse(0);
    far.set_pins(16'h0000);
    settle();
    rd(8'h40, tv(0));
    rd(8'h44, tv(1));
    rd(8'h48, tv(1));
    rd(STAT_OFS, 32'h7);
    wr(STAT_OFS, 32'hffff);
    for (int i = 3; i < 8; i++) begin
      wr(8'(32'h40 + 4 * i), tv(3));
      wr(8'(32'h80 + 4 * i), cf(i == 7, md[i-3]));
    end
    repeat (2) far.count_pulse(0);
    settle();
    rd(PIN_OFS, 32'h98);
    rd(STAT_OFS, 32'hf8);
    check(cc_pin_oe[3], 1'b1);
    check(cc_pin_oe[0], 1'b0);
    // Second match in the same period
    wr(STAT_OFS, 32'hffff);
    wr(T0_OFS, tv(2));
    far.count_pulse(0);
    settle();
    rd(PIN_OFS, 32'h90);
    rd(STAT_OFS, 32'h28);
    wr(MASK_OFS, 32'h20);
    repeat (3) @(posedge sys_clk);
    check(irq, 1'b1);
    wr(MASK_OFS, 32'h10);
    repeat (3) @(posedge sys_clk);
    check(irq, 1'b0);
    wr(MASK_OFS, 32'h20);
    wr(STAT_OFS, 32'h20);
    repeat (3) @(posedge sys_clk);
    check(irq, 1'b0);
    // Overflow reloads and clears set/clear pins
    wr(RL0_OFS, tv(2));
    wr(T0_OFS, 32'hffff);
    far.count_pulse(0);
    settle();
    rd(T0_OFS, tv(2));
    rd(PIN_OFS, 32'h80);
    wr(STAT_OFS, 32'hffff);
    far.count_pulse(0);
    settle();
    rd(STAT_OFS, 32'h78);
    rd(PIN_OFS, 32'h98);
    // Pair 1 and 9 share pin 1
    wr(8'h44, tv(4));
    wr(8'h84, cf(0, CMP_TOG));
    wr(8'h64, tv(5));
    wr(8'ha4, cf(0, CMP_TOG));
    wr(DBL_OFS, 32'h2);
    far.count_pulse(0);
    settle();
    rd(PIN_OFS, 32'h9a);
    far.count_pulse(0);
    settle();
    rd(PIN_OFS, 32'h98);
    check(cc_pin_oe[9], 1'b0);
    // Timer 1 on its count input, then staggered prescale over 64 edges
    wr(T1_OFS, 32'h0);
    wr(CTRL_OFS, 32'h00ff);
    far.count_pulse(1);
    rd(T1_OFS, 32'h1);
    wr(CTRL_OFS, 32'h013f);
    repeat (60) @(posedge sys_clk);
    wr(CTRL_OFS, 32'h012f);
    rd(T1_OFS, 32'h9);
    // Lane 0 strobe only touches the low byte
    wr(MASK_OFS, 32'hffff, RESP_OK, 4'h1);
    rd(MASK_OFS, 32'hff);
    print_verdict();
  end
endmodule // tb_dual_timebase_capture_compare
`default_nettype wire
